// >>> rtl/power_source_and_state_sequencer.sv
// Purpose: Power source selection, power-up sequencing, power states, wake,
//          reset sources, brownout flag and system clock divide and gating
// Assumes: Comparator and pin levels arrive asynchronously; oscillator tick,
//          watchdog, timer and interrupt inputs are on clk
// Notes:
// Notes on behaviour
// - Both sources good: battery powers all domains.
// - Battery low, field present: field powers domains.
// - Battery loss switches to field at once.
// - Battery switch open until reset rise or field.
// - Field switch closes whenever field is present.
// - Battery off command opens switch without field.
// - Auto switch disabled forces battery selection.
// - Enabled brownout raises flag on low rail.
// - Each regulator has its own enable.
// - Flags: 00 active, 10 powerdown, 01 sleep.
// - Timer tick starts digital, then analog stage.
// - Reset releases on regulator and osc; boot after flash.
// - Power-up sequence lasts about 2.5 ms.
// - Field-only power runs the same sequence.
// - Timer tick divider always runs, no disable.
// - System clock is 8 MHz over power of two.
// - Any reset restores the 500 kHz setting.
// - Per-peripheral gating; sensor clock fixed.
// - Reset from pin, watchdog or software request.
// - Deep sleep wake events listed, to active.
// - Powerdown wake events; watchdog does not wake.
// - Mode select chooses sleep, deep sleep, powerdown.
`timescale 1ns/100ps
`default_nettype none

module power_source_and_state_sequencer #(
  parameter int STAGE_CYC = pwr_seq_pkg::STAGE_CYC
) (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            sys_rst,
  // Asynchronous pins and comparators
  input  wire logic                            external_reset_pin_n,
  input  wire logic                            wake_pin,
  input  wire logic                            battery_above_min,
  input  wire logic                            field_above_min,
  input  wire logic                            brownout_low,
  // Same-clock status and events
  input  wire logic                            fast_osc_tick,
  input  wire logic                            fast_osc_stable,
  input  wire logic                            flash_ready,
  input  wire logic                            watchdog_reset,
  input  wire logic                            watchdog_irq,
  input  wire logic                            sw_reset_req,
  input  wire logic                            rtc_match,
  input  wire logic                            start_logic_irq,
  input  wire logic                            irq_pending,
  // Control bits
  input  wire logic                            auto_switch_enable,
  input  wire logic                            battery_off_cmd,
  input  wire logic                            brownout_enable,
  input  wire logic                            lowpower_req,
  input  wire logic [1:0]                      lowpower_mode,
  input  wire logic                            wake_pin_enable,
  input  wire logic                            field_wake_enable,
  input  wire logic                            div_sel_load,
  input  wire logic [2:0]                      div_sel_in,
  input  wire logic [pwr_seq_pkg::GATE_W-1:0]  clock_gate_register,
  // Power switches and regulators
  output logic                                 battery_power_switch,
  output logic                                 field_power_switch,
  output logic                                 domains_from_field,
  output logic                                 digital_regulator_en,
  output logic                                 analog_regulator_en,
  // State flags and resets
  output logic                                 deep_powerdown_flag,
  output logic                                 sleep_flag,
  output logic                                 system_reset,
  output logic                                 boot_enable,
  output logic                                 brownout_irq,
  // Clock enables
  output logic                                 slow_timer_tick,
  output logic                                 sys_clk_en,
  output logic [pwr_seq_pkg::GATE_W-1:0]       periph_clk_en,
  output logic                                 temp_sensor_clk_en
);

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  logic [pwr_seq_pkg::NSYNC-1:0] async_in;  // Raw asynchronous levels
  logic [pwr_seq_pkg::NSYNC-1:0] filt_q;    // Agreed, filtered levels

  assign async_in = {brownout_low, field_above_min, battery_above_min,
                     wake_pin, external_reset_pin_n};

  // Three stages; value counts once stages two and three agree
  generate
    for (genvar i = 0; i < pwr_seq_pkg::NSYNC; i++) begin : g_sync
      logic s1_q, s2_q, s3_q;  // Chain stages
      logic f_d;               // Next filtered value
      always_comb begin
        f_d = (s2_q == s3_q) ? s3_q : filt_q[i];
      end
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          s1_q      <= pwr_seq_pkg::SYNC_RST_VAL[i];
          s2_q      <= pwr_seq_pkg::SYNC_RST_VAL[i];
          s3_q      <= pwr_seq_pkg::SYNC_RST_VAL[i];
          filt_q[i] <= pwr_seq_pkg::SYNC_RST_VAL[i];
        end else begin
          s1_q      <= async_in[i];
          s2_q      <= s1_q;
          s3_q      <= s2_q;
          filt_q[i] <= f_d;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Decoded conditions
  // ---------------------------------------------------------------------------
  logic rst_low;    // Reset pin held low
  logic rst_rise;   // Reset pin released
  logic rf;         // Field present
  logic batt_ok;    // Battery above minimum
  logic wake_low;   // Wake pin pulled low
  logic rstpin_prev_q;

  assign rst_low  = ~filt_q[pwr_seq_pkg::SY_RSTPIN];
  assign rst_rise = filt_q[pwr_seq_pkg::SY_RSTPIN] & ~rstpin_prev_q;
  assign rf       = filt_q[pwr_seq_pkg::SY_FIELD];
  assign batt_ok  = filt_q[pwr_seq_pkg::SY_BATT];
  assign wake_low = ~filt_q[pwr_seq_pkg::SY_WAKE];

  // ---------------------------------------------------------------------------
  // Timer tick divider
  // ---------------------------------------------------------------------------
  logic [pwr_seq_pkg::SLOW_W-1:0] slow_cnt_q, slow_cnt_d; // Tick counter
  logic                           slow_tick;              // Timer tick

  // Free running with no disable input
  always_comb begin
    slow_tick  = (slow_cnt_q == pwr_seq_pkg::SLOW_W'(pwr_seq_pkg::SLOW_DIV_CYC - 1));
    slow_cnt_d = slow_tick ? '0 : slow_cnt_q + 1'b1;
  end

  // ---------------------------------------------------------------------------
  // Source selection
  // ---------------------------------------------------------------------------
  logic armed_q, armed_d;      // Battery switch trigger seen
  logic bat_sw_d, fld_sw_d;    // Next switch states
  logic from_fld_d;            // Next domain source
  logic powered;               // Always-on rail has a source

  // Trigger latch and switch decisions
  always_comb begin
    armed_d = armed_q;
    if (rst_rise || rf) begin
      armed_d = 1'b1;
    end else if (battery_off_cmd) begin
      armed_d = 1'b0;
    end
    bat_sw_d   = armed_d & (~auto_switch_enable | batt_ok);
    fld_sw_d   = rf;
    // Field feeds domains only when battery lost with auto switch on; field always arms
    from_fld_d = rf & (~armed_d | (auto_switch_enable & ~batt_ok));
    powered    = (bat_sw_d & batt_ok) | rf;
  end

  // ---------------------------------------------------------------------------
  // State sequencer
  // ---------------------------------------------------------------------------
  pwr_seq_pkg::seq_state_t         state_q, state_d;  // Power state
  logic [pwr_seq_pkg::STAGE_W-1:0] stage_q, stage_d;  // Stage timer
  logic                            stage_end;         // Stage time reached
  logic                            ds_wake, dpd_wake; // Wake conditions

  always_comb begin
    stage_end = (stage_q == pwr_seq_pkg::STAGE_W'(STAGE_CYC - 1));
    ds_wake   = rst_low | rtc_match | watchdog_irq | watchdog_reset | wake_low
              | (rf & field_wake_enable) | start_logic_irq;
    // Watchdog is not a wake source here
    dpd_wake  = rst_low | rtc_match | (wake_low & wake_pin_enable)
              | (rf & field_wake_enable);
    state_d   = state_q;
    stage_d   = stage_q;
    unique case (state_q)
      pwr_seq_pkg::ST_OFF: begin
        // Timer tick starts the sequence
        if (powered && slow_tick) begin
          state_d = pwr_seq_pkg::ST_DIG_UP;
          stage_d = '0;
        end
      end
      pwr_seq_pkg::ST_DIG_UP: begin
        stage_d = stage_q + 1'b1;
        if (stage_end) begin
          state_d = pwr_seq_pkg::ST_ANA_UP;
          stage_d = '0;
        end
      end
      pwr_seq_pkg::ST_ANA_UP: begin
        stage_d = stage_q + 1'b1;
        if (stage_end) begin
          state_d = pwr_seq_pkg::ST_BOOT;
          stage_d = '0;
        end
      end
      pwr_seq_pkg::ST_BOOT: begin
        // Boot waits for flash
        if (flash_ready) begin
          state_d = pwr_seq_pkg::ST_ACTIVE;
        end
      end
      pwr_seq_pkg::ST_ACTIVE: begin
        // Requested low power mode; spare code acts as sleep
        if (lowpower_req) begin
          if (lowpower_mode == pwr_seq_pkg::LP_DEEP_PD) begin
            state_d = pwr_seq_pkg::ST_DPD;
          end else if (lowpower_mode == pwr_seq_pkg::LP_DEEP_SLEEP) begin
            state_d = pwr_seq_pkg::ST_DSLEEP;
          end else begin
            state_d = pwr_seq_pkg::ST_SLEEP;
          end
        end
      end
      pwr_seq_pkg::ST_SLEEP: begin
        // Any interrupt, pin or watchdog reset ends sleep
        if (irq_pending || ds_wake) begin
          state_d = pwr_seq_pkg::ST_ACTIVE;
        end
      end
      pwr_seq_pkg::ST_DSLEEP: begin
        if (ds_wake) begin
          state_d = pwr_seq_pkg::ST_ACTIVE;
        end
      end
      pwr_seq_pkg::ST_DPD: begin
        // Regulators are off, so restart them
        if (dpd_wake) begin
          state_d = pwr_seq_pkg::ST_DIG_UP;
          stage_d = '0;
        end
      end
      default: begin
        state_d = pwr_seq_pkg::ST_OFF;
        stage_d = '0;
      end
    endcase
    // Loss of every source drops the device
    if (!powered) begin
      state_d = pwr_seq_pkg::ST_OFF;
      stage_d = '0;
    end
  end

  // ---------------------------------------------------------------------------
  // Regulators, flags and resets
  // ---------------------------------------------------------------------------
  logic dig_d, ana_d;       // Next regulator enables
  logic dpd_d, slp_d;       // Next state flags
  logic sysrst_d, boot_d;   // Next reset and boot
  logic bod_d;              // Next brownout flag

  always_comb begin
    dig_d = (state_d != pwr_seq_pkg::ST_OFF) && (state_d != pwr_seq_pkg::ST_DPD);
    ana_d = dig_d && (state_d != pwr_seq_pkg::ST_DIG_UP);
    dpd_d = (state_d == pwr_seq_pkg::ST_DPD);
    slp_d = (state_d == pwr_seq_pkg::ST_SLEEP) || (state_d == pwr_seq_pkg::ST_DSLEEP);
    sysrst_d = ~(dig_d & fast_osc_stable) | rst_low | watchdog_reset | sw_reset_req;
    boot_d = ~sysrst_d & ((state_d == pwr_seq_pkg::ST_ACTIVE) || slp_d);
    bod_d  = brownout_enable & filt_q[pwr_seq_pkg::SY_BOD];
  end

  // ---------------------------------------------------------------------------
  // System clock divider and gating
  // ---------------------------------------------------------------------------
  logic [2:0]                    div_sel_q, div_sel_d; // Divide select
  logic [pwr_seq_pkg::DIV_W-1:0] div_cnt_q, div_cnt_d; // Fast tick counter
  logic [pwr_seq_pkg::DIV_W-1:0] sys_mask, ts_mask;    // Low bits to match

  always_comb begin
    div_sel_d = div_sel_q;
    if (system_reset) begin
      div_sel_d = pwr_seq_pkg::DIV_SEL_RST;
    end else if (div_sel_load) begin
      div_sel_d = div_sel_in;
    end
    div_cnt_d = fast_osc_tick ? div_cnt_q + 1'b1 : div_cnt_q;
    sys_mask  = pwr_seq_pkg::DIV_W'((8'h01 << div_sel_q) - 8'h01);
    ts_mask   = pwr_seq_pkg::DIV_W'((8'h01 << pwr_seq_pkg::TSENS_DIV_SEL) - 8'h01);
    sys_clk_en         = fast_osc_tick & ((div_cnt_q & sys_mask) == '0);
    temp_sensor_clk_en = fast_osc_tick & ((div_cnt_q & ts_mask) == '0);
  end

  // One gated enable per peripheral
  generate
    for (genvar g = 0; g < pwr_seq_pkg::GATE_W; g++) begin : g_gate
      assign periph_clk_en[g] = sys_clk_en & clock_gate_register[g];
    end
  endgenerate

  assign slow_timer_tick = slow_tick;

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rstpin_prev_q        <= 1'b1;
      slow_cnt_q           <= '0;
      armed_q              <= 1'b0;
      battery_power_switch <= 1'b0;
      field_power_switch   <= 1'b0;
      domains_from_field   <= 1'b0;
      state_q              <= pwr_seq_pkg::ST_OFF;
      stage_q              <= '0;
      digital_regulator_en <= 1'b0;
      analog_regulator_en  <= 1'b0;
      deep_powerdown_flag  <= 1'b0;
      sleep_flag           <= 1'b0;
      system_reset         <= 1'b1;
      boot_enable          <= 1'b0;
      brownout_irq         <= 1'b0;
      div_sel_q            <= pwr_seq_pkg::DIV_SEL_RST;
      div_cnt_q            <= '0;
    end else begin
      rstpin_prev_q        <= filt_q[pwr_seq_pkg::SY_RSTPIN];
      slow_cnt_q           <= slow_cnt_d;
      armed_q              <= armed_d;
      battery_power_switch <= bat_sw_d;
      field_power_switch   <= fld_sw_d;
      domains_from_field   <= from_fld_d;
      state_q              <= state_d;
      stage_q              <= stage_d;
      digital_regulator_en <= dig_d;
      analog_regulator_en  <= ana_d;
      deep_powerdown_flag  <= dpd_d;
      sleep_flag           <= slp_d;
      system_reset         <= sysrst_d;
      boot_enable          <= boot_d;
      brownout_irq         <= bod_d;
      div_sel_q            <= div_sel_d;
      div_cnt_q            <= div_cnt_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  property p_both_battery;
    @(posedge clk) disable iff (sys_rst)
    (batt_ok && rf && auto_switch_enable && armed_q) |=> (battery_power_switch && !domains_from_field);
  endproperty
  a_both_battery: assert property (p_both_battery) else $error("battery not chosen");

  property p_field_only;
    @(posedge clk) disable iff (sys_rst)
    (!batt_ok && rf && auto_switch_enable) |=> (domains_from_field && field_power_switch);
  endproperty
  a_field_only: assert property (p_field_only) else $error("field not chosen");

  property p_shelf_open;
    @(posedge clk) disable iff (sys_rst)
    (!armed_q && !rst_rise && !rf) |=> (!battery_power_switch && state_q == pwr_seq_pkg::ST_OFF);
  endproperty
  a_shelf_open: assert property (p_shelf_open) else $error("battery switch closed early");

  property p_field_switch;
    @(posedge clk) disable iff (sys_rst)
    ##1 (field_power_switch == $past(rf));
  endproperty
  a_field_switch: assert property (p_field_switch) else $error("field switch wrong");

  property p_batt_off;
    @(posedge clk) disable iff (sys_rst)
    (battery_off_cmd && !rf && !rst_rise) |=> !battery_power_switch;
  endproperty
  a_batt_off: assert property (p_batt_off) else $error("battery switch stays closed");

  property p_forced_batt;
    @(posedge clk) disable iff (sys_rst)
    (!auto_switch_enable && armed_q && !battery_off_cmd) |=> (battery_power_switch && !domains_from_field);
  endproperty
  a_forced_batt: assert property (p_forced_batt) else $error("forced battery ignored");

  property p_brownout;
    @(posedge clk) disable iff (sys_rst)
    (brownout_enable && filt_q[pwr_seq_pkg::SY_BOD]) |=> brownout_irq;
  endproperty
  a_brownout: assert property (p_brownout) else $error("brownout flag missing");

  property p_flags;
    @(posedge clk) disable iff (sys_rst)
    deep_powerdown_flag |-> (!digital_regulator_en && !analog_regulator_en && !sleep_flag);
  endproperty
  a_flags: assert property (p_flags) else $error("powerdown flag with regulators");

  // Reset only drops together with the regulator, after a stable oscillator
  property p_reset_hold;
    @(posedge clk) disable iff (sys_rst)
    !system_reset |-> (digital_regulator_en && $past(fast_osc_stable));
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset released early");

  property p_dpd_watchdog;
    @(posedge clk) disable iff (sys_rst)
    (state_q == pwr_seq_pkg::ST_DPD && powered && !rtc_match && !rst_low && !wake_low && !rf)
      |=> (state_q == pwr_seq_pkg::ST_DPD);
  endproperty
  a_dpd_watchdog: assert property (p_dpd_watchdog) else $error("powerdown left without wake");

endmodule

`default_nettype wire

// >>> rtl/pwr_seq_pkg.sv
// Purpose: Shared constants and types of the power source and state sequencer
// Assumes: Core clock of 50 MHz, one clock domain
// Notes:   Timing counts are derived from times in their own units
`default_nettype none

package pwr_seq_pkg;
  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ       = 50000000;             // Core clock rate
  localparam int CLK_MHZ      = CLK_HZ / 1000000;     // Cycles per microsecond
  localparam int SLOW_OSC_HZ  = 32768;                // Timer oscillator rate
  localparam int SLOW_DIV_CYC = CLK_HZ / SLOW_OSC_HZ; // Cycles per timer tick
  localparam int SLOW_W       = 11;                   // Timer tick counter width
  localparam int SEQ_TOTAL_US = 2500;                 // Trigger to boot, in us
  localparam int STAGE_US     = SEQ_TOTAL_US / 2;     // One regulator stage, in us
  localparam int STAGE_CYC    = STAGE_US * CLK_MHZ;   // One stage, in cycles
  localparam int STAGE_W      = 17;                   // Stage counter width

  // ---------------------------------------------------------------------------
  // System clock divider
  // ---------------------------------------------------------------------------
  localparam int         DIV_W         = 7;    // Divider counter width
  localparam logic [2:0] DIV_SEL_RST   = 3'h4; // Divide by 16: 500 kHz
  localparam logic [2:0] TSENS_DIV_SEL = 3'h3; // Fixed sensor divide by 8
  localparam int         GATE_W        = 16;   // Gated peripheral clocks

  // ---------------------------------------------------------------------------
  // Synchronised inputs
  // ---------------------------------------------------------------------------
  localparam int               NSYNC        = 5;     // Number of async inputs
  localparam int               SY_RSTPIN    = 0;     // External reset pin, low active
  localparam int               SY_WAKE      = 1;     // Wake pin, low active
  localparam int               SY_BATT      = 2;     // Battery above minimum
  localparam int               SY_FIELD     = 3;     // Field above minimum
  localparam int               SY_BOD       = 4;     // Always-on rail low
  localparam logic [NSYNC-1:0] SYNC_RST_VAL = 5'h03; // Pins idle high

  // ---------------------------------------------------------------------------
  // Modes and states
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    LP_SLEEP      = 2'h0,
    LP_DEEP_SLEEP = 2'h1,
    LP_DEEP_PD    = 2'h2
  } lp_mode_t;

  typedef enum logic [7:0] {
    ST_OFF    = 8'h01, // No power or not started
    ST_DIG_UP = 8'h02, // Digital regulator starting
    ST_ANA_UP = 8'h04, // Analog regulator and flash starting
    ST_BOOT   = 8'h08, // Waiting for flash ready
    ST_ACTIVE = 8'h10, // Running
    ST_SLEEP  = 8'h20, // Sleep
    ST_DSLEEP = 8'h40, // Deep sleep
    ST_DPD    = 8'h80  // Deep power-down
  } seq_state_t;
endpackage

`default_nettype wire

// >>> sim/supply_model.sv
// Purpose: Far-side model of supply rails, reset pin and wake pin
// Assumes: Bench sets the levels; pins rest high when not pressed
// Notes:   Comparator outputs follow the modelled rails directly
`timescale 1ns/100ps
`default_nettype none
module supply_model (
  // Bench controls
  input  wire logic batt_on,
  input  wire logic field_on,
  input  wire logic rst_press,
  input  wire logic sag,
  input  wire logic wake_press,
  // Device pins
  output logic      external_reset_pin_n,
  output logic      wake_pin,
  output logic      battery_above_min,
  output logic      field_above_min,
  output logic      brownout_low
);
  assign battery_above_min    = batt_on;    // Battery above minimum
  assign field_above_min      = field_on;   // Field present
  assign external_reset_pin_n = ~rst_press; // Pulled up unless pressed
  assign wake_pin             = ~wake_press; // High unless pulsed low
  assign brownout_low         = sag;        // Rail droop
endmodule
`default_nettype wire

// >>> sim/tb.sv
// Purpose: Self-checking bench of the power source and state sequencer
// Assumes: Stage length cut to 8 cycles; inputs move on the falling edge
// Notes:   Fast oscillator tick held high, one tick per cycle
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk, sys_rst, batt_on, field_on, rst_press, sag, rst_n, wake, b_ok, f_ok, bo;
  logic ld, lp_req, wd_irq, rtc, auto_en, bo_en, bsw, fsw, from_f, dig, ana, dpd, slp;
  logic srst, boot, bo_irq, stick, sce, tce;
  logic wd_rst, sw_rst, boff, irqp, wk_en, wp;
  logic [1:0]  lp_mode;
  logic [2:0]  dsel;
  logic [15:0] pce, gate;
  int          fails, checked, n, m;
  supply_model i_sup (.batt_on(batt_on), .field_on(field_on), .rst_press(rst_press),
    .sag(sag), .wake_press(wp), .external_reset_pin_n(rst_n), .wake_pin(wake),
    .battery_above_min(b_ok),
    .field_above_min(f_ok), .brownout_low(bo));
  power_source_and_state_sequencer #(.STAGE_CYC(8)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .external_reset_pin_n(rst_n), .wake_pin(wake), .battery_above_min(b_ok),
    .field_above_min(f_ok), .brownout_low(bo), .fast_osc_tick(1'b1), .fast_osc_stable(1'b1),
    .flash_ready(1'b1), .watchdog_reset(wd_rst), .watchdog_irq(wd_irq), .sw_reset_req(sw_rst),
    .rtc_match(rtc), .start_logic_irq(1'b0), .irq_pending(irqp), .auto_switch_enable(auto_en),
    .battery_off_cmd(boff), .brownout_enable(bo_en), .lowpower_req(lp_req),
    .lowpower_mode(lp_mode), .wake_pin_enable(wk_en), .field_wake_enable(bo_en),
    .div_sel_load(ld), .div_sel_in(dsel), .clock_gate_register(gate),
    .battery_power_switch(bsw), .field_power_switch(fsw), .domains_from_field(from_f),
    .digital_regulator_en(dig), .analog_regulator_en(ana), .deep_powerdown_flag(dpd),
    .sleep_flag(slp), .system_reset(srst), .boot_enable(boot), .brownout_irq(bo_irq),
    .slow_timer_tick(stick), .sys_clk_en(sce), .periph_clk_en(pce), .temp_sensor_clk_en(tce));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Compare one result and count it
  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask
  task step(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Arming by the reset pin and the start-up stages
  task t_arm;
    batt_on = 1'b1;
    step(20);
    chk(bsw, 0, "switch closed early");
    rst_press = 1'b1;
    step(10);
    rst_press = 1'b0;
    step(10);
    chk({bsw, from_f}, 2'b10, "battery not used");
    for (int i = 0; i < 2000 && dig !== 1'b1; i++) @(negedge clk);
    chk({dig, ana}, 2'b10, "digital stage");
    // Two stages of 8 cycles, then one cycle for flash ready
    for (n = 0; n < 100 && boot !== 1'b1; n++) @(negedge clk);
    chk(n, 17, "sequence length");
    chk({ana, srst, dpd, slp}, 4'b1000, "active state");
    $display("done arm");
  endtask
  // Divider default, reload and gating
  task t_clk;
    for (int s = 0; s < 3; s++) begin
      n = 0;
      m = 0;
      for (int i = 0; i < 64; i++) begin
        n += sce;
        m += tce;
        if (sce) chk(pce, gate, "gating");
        @(negedge clk);
      end
      chk(n, (s == 1) ? 64 : 4, "system clock rate");
      chk(m, 8, "sensor clock rate");
      gate = 16'h0F0F;
      ld = (s == 0);
      sw_rst = (s == 1);
      step(1);
      chk({srst, boot}, {sw_rst, ~sw_rst}, "software reset");
      {ld, sw_rst} = 2'b00;
      step(1);
    end
    $display("done clk");
  endtask
  // Sleep, deep sleep then deep power-down with wake
  task t_low;
    lp_req = 1'b1;
    step(1);
    lp_req = 1'b0;
    chk({dpd, slp, dig}, 3'b011, "sleep flags");
    irqp = 1'b1;
    step(1);
    irqp = 1'b0;
    chk(slp, 0, "sleep wake");
    lp_mode = 2'h1;
    lp_req = 1'b1;
    step(1);
    lp_req = 1'b0;
    step(3);
    chk({dpd, slp, dig}, 3'b011, "deep sleep flags");
    wd_rst = 1'b1;
    step(1);
    chk({slp, srst}, 2'b01, "deep sleep wake");
    wd_rst = 1'b0;
    wd_irq = 1'b1;
    step(2);
    lp_mode = 2'h2;
    lp_req = 1'b1;
    step(1);
    lp_req = 1'b0;
    step(6);
    chk({dpd, slp, dig, ana, srst}, 5'b10001, "powerdown");
    wd_irq = 1'b0;
    rtc = 1'b1;
    step(1);
    rtc = 1'b0;
    for (int i = 0; i < 20 && dig !== 1'b1; i++) @(negedge clk);
    chk({dig, ana}, 2'b10, "stages rerun");
    for (int i = 0; i < 100 && boot !== 1'b1; i++) @(negedge clk);
    chk(dpd, 0, "powerdown wake");
    lp_req = 1'b1;
    step(1);
    lp_req = 1'b0;
    wp = 1'b1;
    step(20);
    chk(dpd, 1, "wake pin disabled");
    wk_en = 1'b1;
    // Low pulse of 100 us at 20 ns per cycle
    step(5000);
    wp = 1'b0;
    chk({dpd, boot}, 2'b01, "wake pin wake");
    $display("done low");
  endtask
  // Source switch over, forced battery and brownout
  task t_src;
    field_on = 1'b1;
    sag = 1'b1;
    step(8);
    chk({bsw, fsw, from_f, bo_irq}, 4'b1101, "both sources");
    batt_on = 1'b0;
    step(6);
    chk({fsw, from_f}, 2'b11, "field power");
    batt_on = 1'b1;
    step(8);
    chk(from_f, 0, "back to battery");
    auto_en = 1'b0;
    batt_on = 1'b0;
    step(8);
    chk({bsw, from_f}, 2'b10, "forced battery");
    {auto_en, batt_on, field_on, boff} = 4'b1101;
    step(8);
    chk({bsw, fsw, dig}, 3'b000, "battery off");
    $display("done src");
  endtask
  task complete_run;
    $display("fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {batt_on, field_on, rst_press, sag, ld, lp_req, wd_irq, rtc, bo_en} = '0;
    {wd_rst, sw_rst, boff, irqp, wk_en, wp} = '0;
    gate = 16'h00F0;
    {sys_rst, auto_en, lp_mode, dsel, fails, checked} = {2'b11, 5'h00, 64'h0};
    bo_en = 1'b1;
    step(5);
    sys_rst = 1'b0;
    t_arm;
    t_clk;
    t_low;
    t_src;
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    complete_run;
  end
endmodule
`default_nettype wire
